// ### bench/tb_sfie_unit.sv
// self-checking testbench of the vector floating-point exception unit
module tb_sfie_unit
   import sfie_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [31:0] res;
      logic [2:0] fl;
      logic wd, wf, vf, uf;
   } sfie_exp_t;
   typedef struct packed {
      sfie_op_t op;
      sfie_pred_t pred;
      logic [31:0] s1, s2, res;
      logic inv;
   } sfie_vec_t;
   localparam logic [31:0] DP = 32'h3F80_0000;
   localparam logic [31:0] CS = ADDR_CTRL_STATUS;
   localparam logic [31:0] R4 = ADDR_CTRL_REG_FOUR;
   logic clock, resetn, ce, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd, a, b;
   logic reqValid, respValid, vectorFpFault, invalidOpcodeFault;
   logic flushToZero, denormalsZero;
   sfie_req_t req;
   sfie_resp_t resp;
   sfie_exp_t expq[$];
   sfie_vec_t vecs[$];
   int miscompares, samples_checked;

   sfie_unit i_sfie_unit (.clock(clock), .resetn(resetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reqValid(reqValid), .req(req), .respValid(respValid), .resp(resp),
      .vectorFpFault(vectorFpFault),
      .invalidOpcodeFault(invalidOpcodeFault),
      .flushToZero(flushToZero), .denormalsZero(denormalsZero));

   // ----------------------------------------------------------------
   // clock, watchdog, verdict
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // whole run is well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      close_out();
   end
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic fail(string m);
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic chk32(logic [31:0] g, logic [31:0] e, string m);
      samples_checked++;
      if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
   endtask
   task automatic chk_resp(sfie_exp_t e);
      samples_checked++;
      if ({vectorFpFault, invalidOpcodeFault, resp.writeDest, resp.writeFlags}
            !== {e.vf, e.uf, e.wd, e.wf} || (e.wd && resp.result !== e.res)
            || (e.wf && resp.statusFlags !== e.fl))
         fail($sformatf("resp %h exp %h", {resp, vectorFpFault,
            invalidOpcodeFault}, e));
   endtask
   // ----------------------------------------------------------------
   // drivers
   // ----------------------------------------------------------------
   task automatic apb(logic w, logic [31:0] ad, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail("no pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(logic [31:0] ad, logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk32(rd, e, "read");
   endtask
   task automatic issue(sfie_op_t op, sfie_pred_t pr, logic [31:0] s1,
         logic [31:0] s2, logic [31:0] dp, logic [5:1] ox, sfie_exp_t e);
      @(posedge clock);
      reqValid <= 1'b1;
      req <= '{op, pr, s1, s2, dp, 3'h0, ox};
      expq.push_back(e);
   endtask
   task automatic quiet();
      @(posedge clock);
      reqValid <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   task automatic ent(sfie_op_t op, logic [31:0] s1, logic [31:0] s2,
         logic inv, logic [31:0] res);
      vecs.push_back('{op, PRED_EQ, s1, s2, res, inv});
   endtask
   // issues every table entry back to back
   task automatic run_table(logic mk, logic os);
      sfie_exp_t e;
      foreach (vecs[i]) begin
         e.vf = !mk && vecs[i].inv && os;
         e.uf = !mk && vecs[i].inv && !os;
         e.wd = !(e.vf || e.uf) && vecs[i].op != OP_COMI;
         e.wf = !(e.vf || e.uf) && vecs[i].op == OP_COMI;
         e.res = vecs[i].res;
         e.fl = FLAGS_UNORDERED;
         issue(vecs[i].op, vecs[i].pred, vecs[i].s1, vecs[i].s2, DP, 5'h0, e);
      end
      quiet();
   endtask
   // results are judged in mid-cycle, after the registered outputs settle
   always @(negedge clock) begin
      if (resetn === 1'b1) begin
         if (respValid === 1'b1) begin
            if (expq.size() == 0) fail("unexpected response");
            else chk_resp(expq.pop_front());
         end else if ({vectorFpFault, invalidOpcodeFault} !== 2'b00)
            fail("fault without response");
      end
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {ce, resetn, psel, penable, pwrite, reqValid} = 6'b100000;
      {paddr, pwdata, req} = '0;
      void'($urandom(36));
      ent(OP_ADD, 32'h7F80_0001, DP, 1, 32'h7FC0_0001);
      ent(OP_SUB, DP, 32'hFF80_0005, 1, 32'hFFC0_0005);
      ent(OP_MUL, 32'h7FA0_0000, DP, 1, 32'h7FE0_0000);
      ent(OP_DIV, DP, 32'h7F80_0010, 1, 32'h7FC0_0010);
      ent(OP_SQRT, 32'h7F80_0003, 32'h7F80_0003, 1, 32'h7FC0_0003);
      ent(OP_F2F, 32'h7F80_0004, 32'h7F80_0004, 1, 32'h7FC0_0004);
      ent(OP_SQRT, 32'hBF80_0000, 32'hBF80_0000, 1, QNAN_INDEFINITE);
      ent(OP_SQRT, 32'h8000_0000, 32'h8000_0000, 0, DP);
      ent(OP_MAXMIN, 32'h7FC0_0000, 32'h4000_0000, 0, 32'h4000_0000);
      ent(OP_MAXMIN, DP, 32'h7FC0_0000, 0, 32'h7FC0_0000);
      ent(OP_ADD, 32'h7F80_0000, 32'hFF80_0000, 1, QNAN_INDEFINITE);
      ent(OP_SUB, 32'hFF80_0000, 32'hFF80_0000, 1, QNAN_INDEFINITE);
      ent(OP_MUL, 32'h7F80_0000, 32'h0000_0000, 1, QNAN_INDEFINITE);
      ent(OP_DIV, 32'h0000_0000, 32'h8000_0000, 1, QNAN_INDEFINITE);
      ent(OP_DIV, 32'h7F80_0000, 32'hFF80_0000, 1, QNAN_INDEFINITE);
      ent(OP_F2I, 32'h7FC0_0000, 32'h7FC0_0000, 1, INT_INDEFINITE);
      ent(OP_F2I, 32'h7F80_0000, 32'h7F80_0000, 1, INT_INDEFINITE);
      ent(OP_F2I, 32'h4F00_0000, 32'h4F00_0000, 1, INT_INDEFINITE);
      ent(OP_F2I, INT_MIN_AS_FLOAT, INT_MIN_AS_FLOAT, 0, DP);
      ent(OP_ADD, 32'h7FC0_0000, DP, 0, DP);
      ent(OP_COMI, 32'h7FC0_0000, DP, 1, DP);
      for (int p = 0; p < 8; p++) begin
         ent(OP_CMP, 32'h7FC0_0000, DP, p inside {1, 2, 5, 6},
            p inside {3, 4, 5, 6} ? MASK_ALL_ONES : MASK_ALL_ZEROS);
         vecs[vecs.size()-1].pred = sfie_pred_t'(p);
      end
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      rdchk(CS, CTRL_STATUS_RESET);
      rdchk(R4, CTRL_REG_FOUR_RESET);
      apb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
      chk32({31'h0, err}, 32'h1, "slverr");
      rdchk(CS, CTRL_STATUS_RESET);
      apb(1'b1, CS, 32'hFFFF_FFFF);
      rdchk(CS, CTRL_STATUS_WMASK);
      chk32({30'h0, flushToZero, denormalsZero}, 32'h3, "modes");
      apb(1'b1, CS, CTRL_STATUS_RESET);
      apb(1'b1, R4, 32'hFFFF_FFFF);
      rdchk(R4, 32'h0000_0400);
      $display("register test done");
      issue(OP_ADD, PRED_EQ, 32'h7FC0_0000, DP, DP, 5'h0,
         '{DP, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0});
      quiet();
      rdchk(CS, CTRL_STATUS_RESET);
      run_table(1'b1, 1'b1);
      rdchk(CS, 32'h0000_1F81);
      $display("masked test done");
      apb(1'b1, CS, 32'h0000_1F00);
      run_table(1'b0, 1'b1);
      rdchk(CS, 32'h0000_1F01);
      apb(1'b1, R4, 32'h0);
      apb(1'b1, CS, 32'h0000_9F40);
      run_table(1'b0, 1'b0);
      apb(1'b1, CS, 32'h0000_9FC0);
      run_table(1'b1, 1'b0);
      $display("unmasked test done");
      apb(1'b1, R4, 32'h0000_0400);
      apb(1'b1, CS, 32'h0000_1D80);
      issue(OP_ADD, PRED_EQ, DP, DP, DP, 5'b00010,
         '{DP, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0});
      issue(OP_ADD, PRED_EQ, DP, DP, DP, 5'b00001,
         '{DP, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0});
      quiet();
      apb(1'b1, CS, 32'h0);
      for (int i = 0; i < 20; i++) begin
         a = {1'($urandom()), 8'($urandom_range(254, 1)), 23'($urandom())};
         b = {1'($urandom()), 8'($urandom_range(254, 1)), 23'($urandom())};
         rd = $urandom();
         issue(sfie_op_t'($urandom_range(2, 0)), PRED_EQ, a, b, rd, 5'h0,
            '{rd, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0});
      end
      quiet();
      // a signaling NaN held while enable is low must leave no trace
      @(posedge clock);
      ce <= 1'b0;
      reqValid <= 1'b1;
      req.src1 <= 32'h7F80_0001;
      repeat (3) @(posedge clock);
      reqValid <= 1'b0;
      ce <= 1'b1;
      rdchk(CS, 32'h0);
      $display("other exception test done");
      chk32(32'(expq.size()), 32'h0, "pending");
      close_out();
   end
endmodule

// ### hw/sfie_unit.sv
// vector floating-point exception unit with invalid-operation handling
// ------------------------------------------------------------------
// How it works
// RULE_01: fault raised in the cycle after the instruction completes.
// RULE_02: six flag bits and six mask bits live in control/status.
// RULE_03: APB write loads masks; APB read returns masks and flags.
// RULE_04: unmasked exception with OS support bit set raises vector fault.
// RULE_05: OS support bit clear raises invalid-opcode fault instead.
// RULE_06: invalid flag at bit 0, invalid mask at bit 7.
// RULE_07: masked response overwrites the named destination register.
// RULE_08: arithmetic, sqrt or conversion with signaling NaN returns it quiet.
// RULE_09: masked sqrt of negative non-zero returns quiet NaN indefinite.
// RULE_10: max or min with any NaN returns the second source.
// RULE_11: compare with NaN gives zeros, ones for NEQ, UNORD, NLT, NLE.
// RULE_12: ordered compare-to-flags with NaN sets flags to unordered.
// RULE_13: invalid infinity and zero combinations return quiet NaN indefinite.
// RULE_14: float-to-integer of NaN, infinity or out of range gives indefinite.
// RULE_15: unmasked invalid leaves operands unchanged and calls the handler.
// RULE_16: a quiet NaN alone does not signal invalid.
// RULE_17: quiet NaN signals invalid in flags compare and LT/LE/NLT/NLE.
// RULE_18: flush-to-zero and denormals-are-zero do not touch invalid logic.
// RULE_19: denormal flag at bit 1, mask at bit 8.
// RULE_20: divide-by-zero flag at bit 2, mask at bit 9.
// RULE_21: overflow flag at bit 3, mask at bit 10.
// RULE_22: underflow flag at bit 4, mask at bit 11.
// RULE_23: invalid flag set on detection, masked or not, until reloaded.
//
// The register addresses and register access over APB were left to the implementer.
module sfie_unit
   import sfie_pkg::*;
(
   // clock, reset, enable
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // completed instruction from the datapath
   input wire logic reqValid,
   input wire sfie_req_t req,
   // response and faults
   output logic respValid,
   output sfie_resp_t resp,
   output logic vectorFpFault,
   output logic invalidOpcodeFault,
   // mode levels for the datapath
   output logic flushToZero,
   output logic denormalsZero
);
   // ----------------------------------------------------------------
   // operand classification
   // ----------------------------------------------------------------
   function automatic logic isNan(input logic [31:0] v);
      return (v[30:23] == EXP_ALL_ONES) && (v[22:0] != '0);
   endfunction
   function automatic logic isSnan(input logic [31:0] v);
      return isNan(v) && !v[QUIET_BIT];
   endfunction
   function automatic logic isInf(input logic [31:0] v);
      return (v[30:23] == EXP_ALL_ONES) && (v[22:0] == '0);
   endfunction
   function automatic logic isZero(input logic [31:0] v);
      return v[30:0] == '0;
   endfunction

   logic [31:0] ctrlStatus;
   logic ctrlRegFour;
   logic [31:0] next_ctrlStatus;

   wire logic [31:0] a = req.src1;
   wire logic [31:0] b = req.src2;
   wire logic nanA = isNan(a);
   wire logic nanB = isNan(b);
   wire logic anyNan = nanA | nanB;
   wire logic anySnan = isSnan(a) | isSnan(b);
   wire logic infA = isInf(a);
   wire logic infB = isInf(b);
   wire logic zeroA = isZero(a);
   wire logic zeroB = isZero(b);
   wire logic signDiffer = a[31] ^ b[31];

   // ----------------------------------------------------------------
   // invalid-operation detection
   // ----------------------------------------------------------------
   // the mode bits are deliberately not read here: a denormal treated
   // as zero must not turn into an infinity-times-zero invalid
   wire logic addInv = (req.op == OP_ADD)
      & infA & infB & signDiffer; // RULE_13 RULE_18
   wire logic subInv = (req.op == OP_SUB)
      & infA & infB & !signDiffer; // RULE_13
   wire logic mulInv = (req.op == OP_MUL)
      & ((infA & zeroB) | (zeroA & infB)); // RULE_13
   wire logic divInv = (req.op == OP_DIV)
      & ((zeroA & zeroB) | (infA & infB)); // RULE_13
   wire logic infInv = addInv | subInv | mulInv | divInv;
   wire logic sqrtNeg = (req.op == OP_SQRT) & a[31] & !zeroA & !nanA; // RULE_09
   wire logic orderedPred = (req.pred == PRED_LT) | (req.pred == PRED_LE)
      | (req.pred == PRED_NLT) | (req.pred == PRED_NLE);
   wire logic onesPred = (req.pred == PRED_NEQ) | (req.pred == PRED_UNORD)
      | (req.pred == PRED_NLT) | (req.pred == PRED_NLE);
   wire logic outOfRange = (a[30:23] >= EXP_INT_LIMIT)
      & (a != INT_MIN_AS_FLOAT);
   wire logic f2iInv = nanA | infA | outOfRange; // RULE_14

   logic invDetect;
   always_comb begin
      unique case (req.op)
         OP_ADD, OP_SUB, OP_MUL, OP_DIV:
            invDetect = anySnan | infInv; // RULE_08 RULE_16
         OP_SQRT, OP_F2F: invDetect = isSnan(a) | sqrtNeg; // RULE_08
         OP_MAXMIN: invDetect = anySnan; // RULE_16
         OP_CMP: invDetect = anySnan | (anyNan & orderedPred); // RULE_17
         OP_COMI: invDetect = anyNan; // RULE_17
         OP_F2I: invDetect = f2iInv;
         default: invDetect = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // masked responses
   // ----------------------------------------------------------------
   wire logic [31:0] quietA = a | (32'h1 << QUIET_BIT);
   wire logic [31:0] quietB = b | (32'h1 << QUIET_BIT);
   logic [31:0] maskedResult;
   logic [2:0] maskedFlags;
   always_comb begin
      maskedResult = req.dpResult;
      maskedFlags = req.dpFlags;
      unique case (req.op)
         OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT, OP_F2F: begin
            if (infInv | sqrtNeg) begin
               maskedResult = QNAN_INDEFINITE; // RULE_09 RULE_13
            end else if (isSnan(a)) begin
               maskedResult = quietA; // RULE_08
            end else if (isSnan(b) & (req.op != OP_SQRT)
                         & (req.op != OP_F2F)) begin
               maskedResult = quietB; // RULE_08
            end
         end
         OP_MAXMIN: begin
            if (anyNan) begin
               maskedResult = b; // RULE_10
            end
         end
         OP_CMP: begin
            if (anyNan) begin
               maskedResult = onesPred ? MASK_ALL_ONES
                  : MASK_ALL_ZEROS; // RULE_11
            end
         end
         OP_COMI: begin
            if (anyNan) begin
               maskedFlags = FLAGS_UNORDERED; // RULE_12
            end
         end
         OP_F2I: begin
            if (f2iInv) begin
               maskedResult = INT_INDEFINITE; // RULE_14
            end
         end
         default: begin
            maskedResult = req.dpResult;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // fault selection
   // ----------------------------------------------------------------
   wire logic [NUM_EXC-1:0] excNow = {req.otherExc, invDetect};
   wire logic [NUM_EXC-1:0] maskNow =
      ctrlStatus[INEXACT_MASK:INVALID_OP_MASK]; // RULE_02
   wire logic unmaskedAny = reqValid & |(excNow & ~maskNow);
   wire logic osSupport = ctrlRegFour;
   // a faulting instruction writes no destination or compare flags, so the handler sees the
   // original operands
   wire logic writeOk = !unmaskedAny; // RULE_15
   wire logic isComi = req.op == OP_COMI;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         respValid <= 1'b0;
         resp <= '0;
         vectorFpFault <= 1'b0;
         invalidOpcodeFault <= 1'b0;
      end else if (ce) begin
         respValid <= reqValid; // RULE_01
         resp.result <= maskedResult;
         resp.statusFlags <= maskedFlags;
         resp.writeDest <= reqValid & writeOk & !isComi; // RULE_07
         resp.writeFlags <= reqValid & writeOk & isComi;
         vectorFpFault <= unmaskedAny & osSupport; // RULE_04
         invalidOpcodeFault <= unmaskedAny & !osSupport; // RULE_05
      end
   end

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   wire logic hitCsr = paddr == ADDR_CTRL_STATUS;
   wire logic hitCr4 = paddr == ADDR_CTRL_REG_FOUR;
   wire logic hitAny = hitCsr | hitCr4;
   wire logic setup = psel & !penable;
   wire logic access = psel & penable & ce;
   wire logic csrWrite = access & pwrite & hitCsr; // RULE_03
   wire logic cr4Write = access & pwrite & hitCr4;
   wire logic [31:0] readMux = hitCsr ? ctrlStatus
      : hitCr4 ? (32'({ctrlRegFour}) << OS_HANDLER_SUPPORT) : '0;

   assign pready = ce;
   assign pslverr = psel & penable & !hitAny;
   assign flushToZero = ctrlStatus[FLUSH_TO_ZERO];
   assign denormalsZero = ctrlStatus[DENORMALS_ZERO];

   // an event landing with a software load still leaves its flag set
   wire logic [NUM_EXC-1:0] flagSet = reqValid ? excNow : '0;
   always_comb begin
      next_ctrlStatus = ctrlStatus;
      if (csrWrite) begin
         next_ctrlStatus = pwdata & CTRL_STATUS_WMASK;
      end
      next_ctrlStatus[INEXACT_FLAG:INVALID_OP_FLAG] =
         next_ctrlStatus[INEXACT_FLAG:INVALID_OP_FLAG] | flagSet; // RULE_23
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         ctrlStatus <= CTRL_STATUS_RESET;
         ctrlRegFour <= CTRL_REG_FOUR_RESET[OS_HANDLER_SUPPORT];
         prdata <= '0;
      end else if (ce) begin
         ctrlStatus <= next_ctrlStatus; // RULE_06 RULE_19 RULE_20
         if (cr4Write) begin
            ctrlRegFour <= pwdata[OS_HANDLER_SUPPORT];
         end
         if (setup & !pwrite) begin
            prdata <= readMux; // RULE_03 RULE_21 RULE_22
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   faults_exclusive_a: assert property (@(posedge clock) disable iff (!resetn)
      !(vectorFpFault & invalidOpcodeFault))
      else $error("both fault kinds raised together");
   vector_fault_os_a: assert property (@(posedge clock) disable iff (!resetn)
      (ce & reqValid & |(excNow & ~maskNow) & osSupport)
      |=> vectorFpFault) // RULE_04
      else $error("vector fault missing with os support");
   opcode_fault_os_a: assert property (@(posedge clock) disable iff (!resetn)
      (ce & reqValid & |(excNow & ~maskNow) & !osSupport)
      |=> invalidOpcodeFault) // RULE_05
      else $error("invalid opcode fault missing");
   unmasked_no_write_a: assert property (@(posedge clock)
      disable iff (!resetn)
      vectorFpFault | invalidOpcodeFault |-> !resp.writeDest) // RULE_15
      else $error("faulting instruction wrote its destination");
   sqrt_negative_a: assert property (@(posedge clock) disable iff (!resetn)
      (ce & reqValid & req.op == OP_SQRT & a[31] & !zeroA & !nanA)
      |=> resp.result == QNAN_INDEFINITE) // RULE_09
      else $error("negative sqrt not indefinite");
   invalid_sticky_a: assert property (@(posedge clock) disable iff (!resetn)
      (ce & ctrlStatus[INVALID_OP_FLAG] & !csrWrite)
      |=> ctrlStatus[INVALID_OP_FLAG]) // RULE_23
      else $error("invalid flag dropped without a load");
   invalid_set_a: assert property (@(posedge clock) disable iff (!resetn)
      (ce & reqValid & invDetect) |=> ctrlStatus[INVALID_OP_FLAG]) // RULE_23
      else $error("invalid flag not set on detection");
   comi_unordered_a: assert property (@(posedge clock) disable iff (!resetn)
      (ce & reqValid & isComi & anyNan)
      |=> resp.statusFlags == FLAGS_UNORDERED) // RULE_12
      else $error("unordered compare flags wrong");
   qnan_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
      (ce & reqValid & req.op == OP_ADD & anyNan & !anySnan & !infInv)
      |-> !invDetect) // RULE_16
      else $error("quiet NaN alone signalled invalid");
   unmapped_err_a: assert property (@(posedge clock) disable iff (!resetn)
      (psel & penable & !hitAny) |-> pslverr)
      else $error("unmapped access not refused");

   // the checks below compare against the encodings themselves, so a
   // broken response mux cannot hide behind its own expression

   ce_freeze_a: assert property (@(posedge clock)
      disable iff (!resetn)
      (!ce & resetn) |=> $stable(ctrlStatus) & $stable(respValid))
      else $error("state moved with enable low");

   maxmin_src2_a: assert property (@(posedge clock) // RULE_10
      disable iff (!resetn)
      (ce & reqValid & req.op == OP_MAXMIN & anyNan)
      |=> resp.result == $past(b))
      else $error("max or min NaN result wrong");

   cmp_mask_a: assert property (@(posedge clock) // RULE_11
      disable iff (!resetn)
      (ce & reqValid & req.op == OP_CMP & anyNan)
      |=> resp.result == (($past(req.pred) inside
         {PRED_NEQ, PRED_UNORD, PRED_NLT, PRED_NLE})
         ? MASK_ALL_ONES : MASK_ALL_ZEROS))
      else $error("compare NaN mask wrong");

   cmp_qnan_inv_a: assert property (@(posedge clock) // RULE_17
      disable iff (!resetn)
      (reqValid & req.op == OP_CMP & anyNan & (req.pred inside
         {PRED_LT, PRED_LE, PRED_NLT, PRED_NLE})) |-> invDetect)
      else $error("ordered predicate NaN not invalid");

   comi_qnan_inv_a: assert property (@(posedge clock) // RULE_17
      disable iff (!resetn)
      (reqValid & isComi & anyNan) |-> invDetect)
      else $error("flags compare NaN not invalid");

   inf_indefinite_a: assert property (@(posedge clock) // RULE_13
      disable iff (!resetn)
      (ce & reqValid & infInv) |=> resp.result == QNAN_INDEFINITE)
      else $error("infinity case not indefinite");

   f2i_indefinite_a: assert property (@(posedge clock) // RULE_14
      disable iff (!resetn)
      (ce & reqValid & req.op == OP_F2I & (nanA | infA))
      |=> resp.result == INT_INDEFINITE)
      else $error("integer indefinite missing");

   snan_quiet_a: assert property (@(posedge clock) // RULE_08
      disable iff (!resetn)
      (ce & reqValid & req.op == OP_ADD & isSnan(a))
      |=> resp.result == ($past(a) | 32'h0040_0000))
      else $error("signaling NaN not quieted");

   masked_write_a: assert property (@(posedge clock) // RULE_07
      disable iff (!resetn)
      (ce & reqValid & !isComi & !unmaskedAny) |=> resp.writeDest)
      else $error("masked result not written");

   fault_timing_a: assert property (@(posedge clock) // RULE_01
      disable iff (!resetn)
      (vectorFpFault | invalidOpcodeFault) |-> respValid)
      else $error("fault apart from its response");

   masked_no_fault_a: assert property (@(posedge clock) // RULE_02
      disable iff (!resetn)
      (ce & reqValid & !(|(excNow & ~maskNow)))
      |=> !vectorFpFault & !invalidOpcodeFault)
      else $error("masked exception faulted");

   unmasked_flags_a: assert property (@(posedge clock) // RULE_15
      disable iff (!resetn)
      (ce & reqValid & unmaskedAny) |=> !resp.writeFlags)
      else $error("faulting compare wrote flags");

   read_csr_a: assert property (@(posedge clock) // RULE_03
      disable iff (!resetn)
      (ce & setup & !pwrite & hitCsr) |=> prdata == $past(ctrlStatus))
      else $error("control/status read wrong");

   read_unmapped_a: assert property (@(posedge clock)
      disable iff (!resetn)
      (ce & setup & !pwrite & !hitAny) |=> prdata == '0)
      else $error("unmapped read not zero");

   cr4_write_a: assert property (@(posedge clock) // RULE_04
      disable iff (!resetn)
      cr4Write |=> osSupport == $past(pwdata[OS_HANDLER_SUPPORT]))
      else $error("support bit write lost");
endmodule

// ### pkg/sfie_pkg.sv
// shared constants and types of the vector floating-point exception unit
package sfie_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_CTRL_STATUS = 32'h0000_0000;
   localparam logic [31:0] ADDR_CTRL_REG_FOUR = 32'h0000_0004;
   localparam logic [31:0] CTRL_STATUS_RESET = 32'h0000_1F80;
   localparam logic [31:0] CTRL_STATUS_WMASK = 32'h0000_9FFF;
   localparam logic [31:0] CTRL_REG_FOUR_RESET = 32'h0000_0000;
   // ----------------------------------------------------------------
   // control/status field positions; OS_HANDLER_SUPPORT is a bit of register four
   // ----------------------------------------------------------------
   localparam int INVALID_OP_FLAG = 0;
   localparam int DENORMAL_FLAG = 1;
   localparam int DIV_ZERO_FLAG = 2;
   localparam int OVERFLOW_FLAG = 3;
   localparam int UNDERFLOW_FLAG = 4;
   localparam int INEXACT_FLAG = 5;
   localparam int DENORMALS_ZERO = 6;
   localparam int INVALID_OP_MASK = 7;
   localparam int DENORMAL_MASK = 8;
   localparam int DIV_ZERO_MASK = 9;
   localparam int OVERFLOW_MASK = 10;
   localparam int UNDERFLOW_MASK = 11;
   localparam int INEXACT_MASK = 12;
   localparam int FLUSH_TO_ZERO = 15;
   localparam int NUM_EXC = 6;
   localparam int OS_HANDLER_SUPPORT = 10;
   // ----------------------------------------------------------------
   // single-precision encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
   localparam logic [7:0] EXP_INT_LIMIT = 8'h9E;
   localparam int QUIET_BIT = 22;
   localparam logic [31:0] QNAN_INDEFINITE = 32'hFFC0_0000;
   localparam logic [31:0] INT_INDEFINITE = 32'h8000_0000;
   localparam logic [31:0] INT_MIN_AS_FLOAT = 32'hCF00_0000;
   localparam logic [31:0] MASK_ALL_ONES = 32'hFFFF_FFFF;
   localparam logic [31:0] MASK_ALL_ZEROS = 32'h0000_0000;
   // zero, parity, carry: all set means not comparable
   localparam logic [2:0] FLAGS_UNORDERED = 3'h7;
   // ----------------------------------------------------------------
   // operation classes and compare predicates
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MUL = 4'h2, OP_DIV = 4'h3,
      OP_SQRT = 4'h4, OP_MAXMIN = 4'h5, OP_CMP = 4'h6, OP_COMI = 4'h7,
      OP_F2I = 4'h8, OP_F2F = 4'h9
   } sfie_op_t;
   typedef enum logic [2:0] {
      PRED_EQ = 3'h0, PRED_LT = 3'h1, PRED_LE = 3'h2, PRED_UNORD = 3'h3,
      PRED_NEQ = 3'h4, PRED_NLT = 3'h5, PRED_NLE = 3'h6, PRED_ORD = 3'h7
   } sfie_pred_t;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      sfie_op_t op;
      sfie_pred_t pred;
      logic [31:0] src1;
      logic [31:0] src2;
      logic [31:0] dpResult;
      logic [2:0] dpFlags;
      logic [NUM_EXC-1:1] otherExc;
   } sfie_req_t;
   typedef struct packed {
      logic [31:0] result;
      logic [2:0] statusFlags;
      logic writeDest;
      logic writeFlags;
   } sfie_resp_t;
endpackage
